// ===== logic/par_pkg.sv
// Package for the auto-reload PWM timer: register offsets, field positions,
// reset values and counter clock codes.
// Assumes a byte-wide register port with 8-bit addresses.
package par_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_DUTY3   = 8'h73;
  localparam logic [7:0] ADDR_DUTY2   = 8'h74;
  localparam logic [7:0] ADDR_DUTY1   = 8'h75;
  localparam logic [7:0] ADDR_DUTY0   = 8'h76;
  localparam logic [7:0] ADDR_WOC     = 8'h77;
  localparam logic [7:0] ADDR_TCS     = 8'h78;
  localparam logic [7:0] ADDR_LCA     = 8'h79;
  localparam logic [7:0] ADDR_RELOAD  = 8'h7a;
  localparam logic [7:0] ADDR_CCS     = 8'h7b;
  localparam logic [7:0] ADDR_CAP1    = 8'h7c;
  localparam logic [7:0] ADDR_CAP2    = 8'h7d;
  // Timer control/status field positions
  localparam int TCS_EXT_CLK   = 7;
  localparam int TCS_CC_LSB    = 4;
  localparam int TCS_RUN       = 3;
  localparam int TCS_FORCE     = 2;
  localparam int TCS_OVF_IE    = 1;
  localparam int TCS_ROLLOVER  = 0;
  // Capture control/status field positions
  localparam int CCS_EDGE_LSB  = 4;
  localparam int CCS_IE_LSB    = 2;
  localparam int CCS_FLAG_LSB  = 0;
  // Output control field positions
  localparam int WOC_OE_LSB    = 4;
  localparam int WOC_POL_LSB   = 0;
  // Reset values, counter top value and channel counts
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] RESET_PRESC = 7'h00;
  localparam logic [7:0] COUNT_TOP  = 8'hff;
  localparam int N_PWM = 4;
  localparam int N_CAP = 2;
  // Prescaler mode (state of the counter tick source)
  typedef enum logic [1:0] {
    PAR_SRC_CPU = 2'b01,
    PAR_SRC_EXT = 2'b10
  } par_src_t;
endpackage

// ===== logic/par_timer.sv
// Auto-reload 8-bit PWM timer with four PWM outputs and two input captures.
// Assumes a same-clock byte register port; pins and external clock are async.
//
// Notes on behaviour
// (RULE1) Counter readable, writable while counting
// (RULE2) Overflow reloads counter from reload register
// (RULE3) Overflow drives outputs to polarity level
// (RULE4) Reload sets period and duty resolution
// (RULE5) Upper nibble enables each output pin
// (RULE6) Lower nibble selects each channel polarity
// (RULE7) Polarity change inverts output immediately
// (RULE8) Duty register gives channel compare value
// (RULE9) Capture status top bits read zero
// (RULE10) Edge bit: zero falling, one rising
// (RULE11) Per-channel capture interrupt enable
// (RULE12) Capture flag cleared by reading capture data
// (RULE13) Capture data holds counter at capture
// (RULE14) All registers reset to zero; src_q resets to PAR_SRC_CPU
// (RULE15) Duty copied to compare at overflow
// (RULE16) Compare match restores pre-overflow level
// (RULE17) Counter write or forced reload clears prescaler
// (RULE18) Rollover flag set at FFh, read-cleared
// (RULE19) Capture request held while flag and enable
// (RULE20) Captures synchronised, one per counter tick
`timescale 1ns/1ns
module par_timer
  import par_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             ext_clk_pin,
  input  wire logic [N_CAP-1:0] capture_input_pin,
  output logic      [N_PWM-1:0] wave_output_pin,
  output logic      [N_PWM-1:0] wave_output_oe_n,
  output logic                  rollover_irq,
  output logic      [N_CAP-1:0] capture_irq
);

  // Register state
  logic [7:0]       duty_q [N_PWM];
  logic [7:0]       duty_d [N_PWM];
  logic [7:0]       cmp_q  [N_PWM];
  logic [7:0]       cmp_d  [N_PWM];
  logic [7:0]       woc_q, woc_d;
  logic [7:0]       tcs_q, tcs_d;
  logic [7:0]       cnt_q, cnt_d;
  logic [7:0]       reload_q, reload_d;
  logic [5:0]       ccs_q, ccs_d;
  logic [7:0]       cap_q [N_CAP];
  logic [7:0]       cap_d [N_CAP];
  logic [6:0]       presc_q, presc_d;
  logic [N_PWM-1:0] raw_q, raw_d;
  logic [7:0]       rdata_q, rdata_d;
  logic [N_CAP-1:0] cap_pend_q, cap_pend_d;
  par_src_t         src_q, src_d;

  // Synchronisers for pins
  logic [N_CAP-1:0] cin_s1_q, cin_s2_q, cin_s3_q;
  logic             ext_s1_q, ext_s2_q, ext_s3_q;

  // Decoded strobes and tick
  logic             tick;
  logic             ovf;
  logic             base_tick;
  logic             ext_edge;
  logic [2:0]       cc_sel;
  logic [N_CAP-1:0] cap_edge;

  // Two-stage synchronisers plus a history stage for edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cin_s1_q <= '0;
      cin_s2_q <= '0;
      cin_s3_q <= '0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else if (clk_en) begin
      cin_s1_q <= capture_input_pin;  // RULE20
      cin_s2_q <= cin_s1_q;
      cin_s3_q <= cin_s2_q;
      ext_s1_q <= ext_clk_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Tick source and prescaler tap
  always_comb begin
    cc_sel    = tcs_q[TCS_CC_LSB +: 3];
    ext_edge  = ext_s2_q & ~ext_s3_q;
    src_d     = tcs_q[TCS_EXT_CLK] ? PAR_SRC_EXT : PAR_SRC_CPU;
    case (src_q)
      PAR_SRC_CPU: base_tick = 1'b1;
      PAR_SRC_EXT: base_tick = ext_edge;
      default:     base_tick = 1'b0;
    endcase
    if (cc_sel == 3'd0) begin
      tick = base_tick;
    end else begin
      tick = base_tick & (presc_q[cc_sel - 3'd1 +: 1] == 1'b1) &
             ((presc_q & ((7'h01 << cc_sel) - 7'h01) >> 1) == ((7'h01 << cc_sel) - 7'h01) >> 1);
    end
    tick = tick & tcs_q[TCS_RUN];
    ovf  = tick & (cnt_q == COUNT_TOP);
  end

  // Capture edges per channel, edge bit picks polarity
  genvar gi;
  generate
    for (gi = 0; gi < N_CAP; gi++) begin : g_edge
      assign cap_edge[gi] = ccs_q[CCS_EDGE_LSB + gi] ?
                            (cin_s2_q[gi] & ~cin_s3_q[gi]) :     // RULE10
                            (~cin_s2_q[gi] & cin_s3_q[gi]);
    end
  endgenerate

  // Next-state logic for counter, registers and outputs
  always_comb begin
    logic [N_PWM-1:0] pol_now;
    pol_now    = woc_q[WOC_POL_LSB +: N_PWM];
    woc_d      = woc_q;
    tcs_d      = tcs_q;
    cnt_d      = cnt_q;
    reload_d   = reload_q;
    ccs_d      = ccs_q;
    presc_d    = presc_q;
    raw_d      = raw_q;
    cap_pend_d = cap_pend_q;
    rdata_d    = RESET_BYTE;
    for (int i = 0; i < N_PWM; i++) begin
      duty_d[i] = duty_q[i];
      cmp_d[i]  = cmp_q[i];
    end
    for (int i = 0; i < N_CAP; i++) begin
      cap_d[i] = cap_q[i];
    end
    // Prescaler advances on each input tick while running
    if (tcs_q[TCS_RUN] && base_tick) begin
      presc_d = presc_q + 7'h01;
    end
    // Counter advance, overflow reload and waveform edges
    if (tick) begin
      if (ovf) begin
        cnt_d = reload_q;                                        // RULE2 RULE4
        for (int i = 0; i < N_PWM; i++) begin
          cmp_d[i] = duty_q[i];                                  // RULE15 RULE8
        end
        raw_d = '1;                                              // RULE3
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
      for (int i = 0; i < N_PWM; i++) begin
        if (!ovf && cnt_q == cmp_q[i]) begin
          raw_d[i] = 1'b0;                                       // RULE16
        end
      end
    end
    // Captures: one per tick domain edge, held until next tick; edges ignored while flag set
    for (int i = 0; i < N_CAP; i++) begin
      if (cap_edge[i] && !ccs_q[CCS_FLAG_LSB + i]) begin
        cap_pend_d[i] = 1'b1;                                    // RULE20
      end
      if (cap_pend_q[i] && tick) begin
        cap_pend_d[i] = 1'b0;
        cap_d[i]      = cnt_q;                                   // RULE13
      end
    end
    // Register reads; rollover and capture flags clear on read
    if (reg_rd) begin
      case (reg_addr)
        ADDR_DUTY3:  rdata_d = duty_q[3];
        ADDR_DUTY2:  rdata_d = duty_q[2];
        ADDR_DUTY1:  rdata_d = duty_q[1];
        ADDR_DUTY0:  rdata_d = duty_q[0];
        ADDR_WOC:    rdata_d = woc_q;
        ADDR_TCS: begin
          rdata_d = tcs_q & ~(8'h01 << TCS_FORCE);
          tcs_d[TCS_ROLLOVER] = 1'b0;                            // RULE18
        end
        ADDR_LCA:    rdata_d = cnt_q;                            // RULE1
        ADDR_RELOAD: rdata_d = reload_q;
        ADDR_CCS:    rdata_d = {2'b00, ccs_q};                   // RULE9
        ADDR_CAP1: begin
          rdata_d = cap_q[0];
          ccs_d[CCS_FLAG_LSB] = 1'b0;                            // RULE12
        end
        ADDR_CAP2: begin
          rdata_d = cap_q[1];
          ccs_d[CCS_FLAG_LSB + 1] = 1'b0;                        // RULE12
        end
        default:     rdata_d = RESET_BYTE;
      endcase
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_DUTY3:  duty_d[3] = reg_wdata;
        ADDR_DUTY2:  duty_d[2] = reg_wdata;
        ADDR_DUTY1:  duty_d[1] = reg_wdata;
        ADDR_DUTY0:  duty_d[0] = reg_wdata;
        ADDR_WOC:    woc_d = reg_wdata;                          // RULE5 RULE6 RULE7
        ADDR_TCS: begin
          tcs_d[7:TCS_OVF_IE] = reg_wdata[7:TCS_OVF_IE];
          tcs_d[TCS_FORCE]    = 1'b0;
          if (reg_wdata[TCS_FORCE]) begin
            cnt_d   = reload_q;
            presc_d = RESET_PRESC;                               // RULE17
          end
        end
        ADDR_LCA: begin
          cnt_d   = reg_wdata;                                   // RULE1
          presc_d = RESET_PRESC;                                 // RULE17
        end
        ADDR_RELOAD: reload_d = reg_wdata;
        ADDR_CCS:    ccs_d[5:2] = reg_wdata[5:2];
        default:     ;
      endcase
    end
    // Hardware sets win over read clears
    if (ovf) begin
      tcs_d[TCS_ROLLOVER] = 1'b1;                                // RULE18
    end
    for (int i = 0; i < N_CAP; i++) begin
      if (cap_pend_q[i] && tick) begin
        ccs_d[CCS_FLAG_LSB + i] = 1'b1;                          // RULE12
      end
    end
  end

  // State registers, cleared by reset except src_q, which loads PAR_SRC_CPU
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N_PWM; i++) begin
        duty_q[i] <= RESET_BYTE;                                 // RULE14
        cmp_q[i]  <= RESET_BYTE;
      end
      for (int i = 0; i < N_CAP; i++) begin
        cap_q[i] <= RESET_BYTE;
      end
      woc_q      <= RESET_BYTE;
      tcs_q      <= RESET_BYTE;
      cnt_q      <= RESET_BYTE;
      reload_q   <= RESET_BYTE;
      ccs_q      <= 6'h00;
      presc_q    <= RESET_PRESC;
      raw_q      <= '0;
      rdata_q    <= RESET_BYTE;
      cap_pend_q <= '0;
      src_q      <= PAR_SRC_CPU;
    end else if (clk_en) begin
      for (int i = 0; i < N_PWM; i++) begin
        duty_q[i] <= duty_d[i];
        cmp_q[i]  <= cmp_d[i];
      end
      for (int i = 0; i < N_CAP; i++) begin
        cap_q[i] <= cap_d[i];
      end
      woc_q      <= woc_d;
      tcs_q      <= tcs_d;
      cnt_q      <= cnt_d;
      reload_q   <= reload_d;
      ccs_q      <= ccs_d;
      presc_q    <= presc_d;
      raw_q      <= raw_d;
      rdata_q    <= rdata_d;
      cap_pend_q <= cap_pend_d;
      src_q      <= src_d;
    end
  end

  // Pin outputs: polarity applied live, enable per channel
  always_comb begin
    reg_rdata = rdata_q;
    for (int i = 0; i < N_PWM; i++) begin
      wave_output_pin[i]  = raw_q[i] ^ woc_q[WOC_POL_LSB + i];    // RULE6 RULE7
      wave_output_oe_n[i] = ~woc_q[WOC_OE_LSB + i];               // RULE5
    end
    rollover_irq = tcs_q[TCS_ROLLOVER] & tcs_q[TCS_OVF_IE];
    for (int i = 0; i < N_CAP; i++) begin
      capture_irq[i] = ccs_q[CCS_FLAG_LSB + i] & ccs_q[CCS_IE_LSB + i]; // RULE11 RULE19
    end
  end

endmodule

// ===== verification/par_checker.sv
// Checker on the timer's register port and pins.
// Assumes the bind below attaches it to each par_timer.
`timescale 1ns/1ns
module par_checker
  import par_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       ext_clk_pin,
  input wire logic [1:0] capture_input_pin,
  input wire logic [3:0] wave_output_pin,
  input wire logic [3:0] wave_output_oe_n,
  input wire logic       rollover_irq,
  input wire logic [1:0] capture_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Register effects at the pins and read port
  chk_oe_follow: assert property (
    reg_wr && reg_addr == ADDR_WOC |=> {4'h0, wave_output_oe_n} == (~$past(reg_wdata) >> 4)) else $error("oe bad");
  chk_ccs_top: assert property (
    reg_rd && reg_addr == ADDR_CCS |=> reg_rdata[7:6] == 2'b00) else $error("ccs top bits set");
  chk_duty_back: assert property (
    reg_wr && reg_addr == ADDR_DUTY0 ##2 reg_rd && reg_addr == ADDR_DUTY0 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("duty readback bad");
  chk_cap_hold: assert property (
    capture_irq[0] && !(reg_rd && reg_addr == ADDR_CAP1) && !(reg_wr && reg_addr == ADDR_CCS) |=> capture_irq[0])
    else $error("capture request dropped");
  chk_cap_clear: assert property (
    reg_rd && reg_addr == ADDR_CAP1 && capture_irq[0] |=> !capture_irq[0]) else $error("capture flag kept");
  chk_cap_mask: assert property (
    reg_wr && reg_addr == ADDR_CCS && !reg_wdata[CCS_IE_LSB] |=> !capture_irq[0]) else $error("capture not masked");
  chk_roll_hold: assert property (
    rollover_irq && !(reg_rd && reg_addr == ADDR_TCS) && !(reg_wr && reg_addr == ADDR_TCS) |=> rollover_irq)
    else $error("rollover request dropped");
  chk_roll_mask: assert property (
    reg_wr && reg_addr == ADDR_TCS && !reg_wdata[TCS_OVF_IE] |=> !rollover_irq) else $error("rollover not masked");
endmodule

bind par_timer par_checker i_chk (.*);

// ===== verification/par_pins.sv
// Far-side model: capture signal sources and a slow external clock.
// Assumes the bench sets the wanted capture levels on cap_lvl.
`timescale 1ns/1ns
module par_pins (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] cap_lvl,
  output logic      [1:0] capture_input_pin,
  output logic            ext_clk_pin
);
  logic [2:0] div_q;
  // Divider and capture levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 3'h0;
      capture_input_pin <= 2'b10;
    end else begin
      div_q <= div_q + 3'h1;
      capture_input_pin <= cap_lvl;
    end
  end
  // One ext period per eight clocks
  assign ext_clk_pin = div_q[2];
endmodule

// ===== verification/tb_top.sv
// Bench for par_timer: registers, PWM timing and captures.
// Assumes par_pins drives capture levels and the ext clock.
`timescale 1ns/1ns
module tb_top
  import par_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] cap_lvl = 2'b10;
  logic [7:0] rdata, v;
  logic [3:0] pin, oe_n;
  logic [1:0] cap_pin, cap_irq;
  logic       ext, ovf_irq, p;
  int         mismatches = 0;
  int         comparisons = 0;
  int         hi, ed;
  always #5 clk = ~clk;
  par_pins i_pins (.clk(clk), .rst(rst), .cap_lvl(cap_lvl), .capture_input_pin(cap_pin), .ext_clk_pin(ext));
  par_timer i_dut (.clk(clk), .rst(rst), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .ext_clk_pin(ext), .capture_input_pin(cap_pin),
    .wave_output_pin(pin), .wave_output_oe_n(oe_n), .rollover_irq(ovf_irq), .capture_irq(cap_irq));
  // One-cycle write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // One-cycle read, data taken in the next cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, v);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    mismatches++;
    results();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 8'h72; a <= 8'h7e; a++) rc(8'(a), 8'h00);
    chk("oe_n", 8'h0f, {4'h0, oe_n});
    for (int i = 0; i < 4; i++) begin
      wr(8'(ADDR_DUTY3 + i), 8'(8'hf5 + i));
      rc(8'(ADDR_DUTY3 + i), 8'(8'hf5 + i));
    end
    wr(ADDR_CAP1, 8'haa);
    rc(ADDR_CAP1, 8'h00);
    wr(ADDR_CCS, 8'hff);
    rc(ADDR_CCS, 8'h3c);
    // Enables and polarity, timer stopped
    wr(ADDR_WOC, 8'h50);
    chk("oe_n", 8'h0a, {4'h0, oe_n});
    chk("pwm", 8'h00, {4'h0, pin});
    wr(ADDR_WOC, 8'h5f);
    chk("pwm", 8'h0f, {4'h0, pin});
    wr(ADDR_WOC, 8'hf0);
    // Slow prescaler, counter load clears it
    wr(ADDR_RELOAD, 8'hf0);
    rc(ADDR_RELOAD, 8'hf0);
    wr(ADDR_TCS, 8'h78);
    repeat (120) @(posedge clk);
    wr(ADDR_LCA, 8'h33);
    repeat (100) @(posedge clk);
    rc(ADDR_LCA, 8'h33);
    // Rising capture on channel one
    wr(ADDR_CCS, 8'h14);
    cap_lvl <= 2'b11;
    for (hi = 0; hi < 300 && cap_irq[0] !== 1'b1; hi++) begin
      @(posedge clk);
      #1;
    end
    chk("cap_irq", 8'h01, {6'h0, cap_irq});
    rc(ADDR_CCS, 8'h15);
    rd(ADDR_CAP1);
    chk("cap1", 8'h01, 8'(v == 8'h33 || v == 8'h34));
    chk("cap_irq", 8'h00, {6'h0, cap_irq});
    // Falling capture on channel two, request masked
    cap_lvl <= 2'b01;
    repeat (300) @(posedge clk);
    chk("cap_irq", 8'h00, {6'h0, cap_irq});
    rc(ADDR_CCS, 8'h16);
    wr(ADDR_CCS, 8'h1c);
    chk("cap_irq", 8'h02, {6'h0, cap_irq});
    rd(ADDR_CAP2);
    chk("cap_irq", 8'h00, {6'h0, cap_irq});
    rc(ADDR_CCS, 8'h1c);
    // Fast count: overflow, reload, waveform
    wr(ADDR_TCS, 8'h0a);
    wr(ADDR_LCA, 8'hfe);
    for (hi = 0; hi < 20 && ovf_irq !== 1'b1; hi++) begin
      @(posedge clk);
      #1;
    end
    chk("ovf_irq", 8'h01, {7'h0, ovf_irq});
    hi = 0;
    ed = 0;
    p = pin[0];
    for (int i = 0; i < 160; i++) begin
      @(posedge clk);
      #1;
      ed += int'(pin[0] === 1'b1 && p === 1'b0);
      hi += int'(pin[0] === 1'b1);
      p = pin[0];
    end
    chk("edges", 8'd10, 8'(ed));
    chk("high", 8'h01, 8'(hi >= 80 && hi <= 90));
    wr(ADDR_TCS, 8'h02);
    rc(ADDR_TCS, 8'h03);
    rc(ADDR_TCS, 8'h02);
    rd(ADDR_LCA);
    chk("reload", 8'h01, 8'(v >= 8'hf0));
    // External clock counting
    wr(ADDR_RELOAD, 8'h00);
    wr(ADDR_LCA, 8'h00);
    wr(ADDR_TCS, 8'h88);
    repeat (80) @(posedge clk);
    wr(ADDR_TCS, 8'h00);
    rd(ADDR_LCA);
    chk("ext", 8'h01, 8'(v >= 8'd9 && v <= 8'd12));
    wr(ADDR_CCS, 8'h00);
    results();
  end
endmodule
